// file: pkg/cct_pkg.sv
package cct_pkg;
	localparam int unsigned CNT_W = 16;
	localparam int unsigned PRESCALE = 4;
	localparam int unsigned ADDR_W = 8;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'hFFFC;
	localparam logic [CNT_W-1:0] CMP_RESET = 16'hFFFF;

	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_CONTROL = 8'h12;
	localparam logic [ADDR_W-1:0] IDX_FLAGS = 8'h13;
	localparam logic [ADDR_W-1:0] IDX_CAP_HI = 8'h14;
	localparam logic [ADDR_W-1:0] IDX_CAP_LO = 8'h15;
	localparam logic [ADDR_W-1:0] IDX_CMP_HI = 8'h16;
	localparam logic [ADDR_W-1:0] IDX_CMP_LO = 8'h17;
	localparam logic [ADDR_W-1:0] IDX_CNT_HI = 8'h18;
	localparam logic [ADDR_W-1:0] IDX_CNT_LO = 8'h19;
	localparam logic [ADDR_W-1:0] IDX_ALT_HI = 8'h1A;
	localparam logic [ADDR_W-1:0] IDX_ALT_LO = 8'h1B;

	// Control register fields
	localparam int unsigned BIT_CAP_IE = 7;
	localparam int unsigned BIT_CMP_IE = 6;
	localparam int unsigned BIT_OVF_IE = 5;
	localparam int unsigned BIT_EDGE_SEL = 1;
	localparam int unsigned BIT_OUT_LVL = 0;

	// Flags register fields
	localparam int unsigned BIT_CAP_FLAG = 7;
	localparam int unsigned BIT_CMP_FLAG = 6;
	localparam int unsigned BIT_OVF_FLAG = 5;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10
	} cct_bus_t;
endpackage

// file: pkg/cct_cnt_if.sv
interface cct_cnt_if #(parameter int unsigned CNT_W = 16);
	logic stop;
	logic tick;
	logic wrap;
	logic [CNT_W-1:0] count;
	modport ctr(input stop, output tick, output wrap, output count);
	modport user(output stop, input tick, input wrap, input count);
endinterface

// file: core/cct_counter.sv
module cct_counter #(
	parameter int unsigned PRESCALE = cct_pkg::PRESCALE
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	cct_cnt_if.ctr cnt // Counter view for the register block
);
	import cct_pkg::*;

	localparam int unsigned PW = $clog2(PRESCALE);
	localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

	logic [PW-1:0] pre_r;
	logic [CNT_W-1:0] count_r;

	// Prescaler is cleared while stopped so the count resumes on a clean phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_r <= '0;
		end else if (cnt.stop) begin
			pre_r <= '0;
		end else if (pre_r == PRE_LAST) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	assign cnt.tick = (pre_r == PRE_LAST) && !cnt.stop;

	// Reset value covers leaving stop by reset; stop by itself only freezes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_r <= CNT_RESET;
		end else if (cnt.tick) begin
			count_r <= count_r + 1'b1;
		end
	end

	assign cnt.wrap = cnt.tick && (count_r == '1);
	assign cnt.count = count_r;
endmodule

// file: core/cct_timer.sv
// The AHB-Lite slave port is this design's own decision.
module cct_timer #(
	parameter int unsigned PRESCALE = cct_pkg::PRESCALE
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic por_n, // Power-on reset for reset-immune state, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic capture_input_pin, // Asynchronous capture pin
	output logic compare_output_pin, // Compare output pin
	input wire logic stop_mode, // Processor in stop, same clock
	output logic timer_irq // Interrupt and wake-up request
);
	import cct_pkg::*;

	cct_cnt_if #(.CNT_W(CNT_W)) cnt();

	cct_counter #(.PRESCALE(PRESCALE)) u_counter (
		.hclk(hclk),
		.hresetn(hresetn),
		.cnt(cnt)
	);

	assign cnt.stop = stop_mode;

	// Bus state
	cct_bus_t bus_r;
	logic [ADDR_W-1:0] addr_r;
	logic [31:0] hrdata_r;
	logic addr_ok_r;

	// Control
	logic cap_ie_r, cmp_ie_r, ovf_ie_r, out_lvl_r, edge_sel_r;

	// Flags and their clear arming
	logic cap_flag_r, cmp_flag_r, ovf_flag_r;
	logic cap_arm_r, cmp_arm_r, ovf_arm_r;

	// Data registers and interlocks
	logic [CNT_W-1:0] capture_r, compare_r, stop_cap_r;
	logic cap_block_r, cmp_hold_r, stop_armed_r;
	logic main_hold_r, alt_hold_r;
	logic [7:0] main_low_r, alt_low_r;

	// Capture pin synchroniser and edge history
	logic cap_s1_r, cap_s2_r, cap_s3_r;
	logic pin_r, irq_r;

	logic bus_take, addr_hit, rd_now, wr_now;
	logic [ADDR_W-1:0] idx_in;
	logic [7:0] wbyte, rd_val;
	logic cap_edge, cap_set, cap_load, cmp_match;
	logic [CNT_W-1:0] cap_value;
	logic cap_clr, cmp_clr, ovf_clr;

	function automatic logic [7:0] low_view(input logic hold, input logic [7:0] held,
			input logic [CNT_W-1:0] cur);
		low_view = hold ? held : cur[7:0];
	endfunction

	function automatic logic is_reg(input logic [ADDR_W-1:0] idx);
		is_reg = (idx >= IDX_CONTROL) && (idx <= IDX_ALT_LO);
	endfunction

	function automatic logic acc(input logic now, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
		acc = now && (a == idx);
	endfunction

	// AHB-Lite slave: writes take no wait state, reads take one so that a write
	// in the preceding data phase is already visible and read side effects land once
	assign bus_take = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign idx_in = haddr[ADDR_W+1:2];
	assign addr_hit = (haddr[31:ADDR_W+2] == '0) && (haddr[1:0] == 2'h0) && is_reg(idx_in);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_r <= BUS_IDLE;
			addr_r <= '0;
			addr_ok_r <= 1'b0;
		end else if (bus_take) begin
			bus_r <= hwrite ? BUS_WRITE : BUS_READ;
			addr_r <= idx_in;
			addr_ok_r <= addr_hit;
		end else if (hreadyout) begin
			bus_r <= BUS_IDLE;
		end else begin
			bus_r <= BUS_IDLE;
		end
	end

	assign hreadyout = (bus_r != BUS_READ);
	assign hresp = HRESP_OKAY;
	assign rd_now = (bus_r == BUS_READ) && addr_ok_r;
	assign wr_now = (bus_r == BUS_WRITE) && addr_ok_r;
	assign wbyte = hwdata[7:0];
	assign hrdata = hrdata_r;

	always_comb begin
		rd_val = 8'h00;
		unique case (addr_r)
			IDX_CONTROL: begin
				rd_val[BIT_CAP_IE] = cap_ie_r;
				rd_val[BIT_CMP_IE] = cmp_ie_r;
				rd_val[BIT_OVF_IE] = ovf_ie_r;
				rd_val[BIT_EDGE_SEL] = edge_sel_r;
				rd_val[BIT_OUT_LVL] = out_lvl_r;
			end
			IDX_FLAGS: begin
				rd_val[BIT_CAP_FLAG] = cap_flag_r;
				rd_val[BIT_CMP_FLAG] = cmp_flag_r;
				rd_val[BIT_OVF_FLAG] = ovf_flag_r;
			end
			IDX_CAP_HI: rd_val = capture_r[15:8];
			IDX_CAP_LO: rd_val = capture_r[7:0];
			IDX_CMP_HI: rd_val = compare_r[15:8];
			IDX_CMP_LO: rd_val = compare_r[7:0];
			IDX_CNT_HI: rd_val = cnt.count[15:8];
			IDX_CNT_LO: rd_val = low_view(main_hold_r, main_low_r, cnt.count);
			IDX_ALT_HI: rd_val = cnt.count[15:8];
			IDX_ALT_LO: rd_val = low_view(alt_hold_r, alt_low_r, cnt.count);
			default: rd_val = 8'h00;
		endcase
	end

	// Unmapped addresses read as zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= '0;
		end else if (bus_r == BUS_READ) begin
			hrdata_r <= rd_now ? {24'h000000, rd_val} : 32'h00000000;
		end
	end

	// Control register: edge select survives hresetn, the rest does not
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_ie_r <= 1'b0;
			cmp_ie_r <= 1'b0;
			ovf_ie_r <= 1'b0;
			out_lvl_r <= 1'b0;
		end else if (acc(wr_now, addr_r, IDX_CONTROL)) begin
			cap_ie_r <= wbyte[BIT_CAP_IE];
			cmp_ie_r <= wbyte[BIT_CMP_IE];
			ovf_ie_r <= wbyte[BIT_OVF_IE];
			out_lvl_r <= wbyte[BIT_OUT_LVL];
		end
	end

	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			edge_sel_r <= 1'b0;
		end else if (acc(wr_now, addr_r, IDX_CONTROL)) begin
			edge_sel_r <= wbyte[BIT_EDGE_SEL];
		end
	end

	// Capture pin: first stage feeds only the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_s1_r <= 1'b0;
			cap_s2_r <= 1'b0;
			cap_s3_r <= 1'b0;
		end else begin
			cap_s1_r <= capture_input_pin;
			cap_s2_r <= cap_s1_r;
			cap_s3_r <= cap_s2_r;
		end
	end

	assign cap_edge = edge_sel_r ? (cap_s2_r && !cap_s3_r) : (!cap_s2_r && cap_s3_r);

	// An edge in stop is parked with the frozen count; only the first one counts.
	// hresetn drops it, so leaving stop by reset leaves neither flag nor data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_armed_r <= 1'b0;
			stop_cap_r <= '0;
		end else if (stop_mode) begin
			if (cap_edge && !stop_armed_r) begin
				stop_armed_r <= 1'b1;
				stop_cap_r <= cnt.count;
			end
		end else begin
			stop_armed_r <= 1'b0;
		end
	end

	assign cap_set = stop_mode ? 1'b0 : (stop_armed_r || cap_edge);
	assign cap_value = stop_armed_r ? stop_cap_r : cnt.count;
	assign cap_load = cap_set && !cap_block_r;

	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			capture_r <= '0;
		end else if (cap_load) begin
			capture_r <= cap_value;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_block_r <= 1'b0;
		end else if (acc(rd_now, addr_r, IDX_CAP_HI)) begin
			cap_block_r <= 1'b1;
		end else if (acc(rd_now, addr_r, IDX_CAP_LO)) begin
			cap_block_r <= 1'b0;
		end
	end

	// Counter views: the high read snapshots the low byte for the following low read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			main_hold_r <= 1'b0;
			main_low_r <= 8'h00;
		end else if (acc(rd_now, addr_r, IDX_CNT_HI)) begin
			main_hold_r <= 1'b1;
			main_low_r <= cnt.count[7:0];
		end else if (acc(rd_now, addr_r, IDX_CNT_LO)) begin
			main_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_hold_r <= 1'b0;
			alt_low_r <= 8'h00;
		end else if (acc(rd_now, addr_r, IDX_ALT_HI)) begin
			alt_hold_r <= 1'b1;
			alt_low_r <= cnt.count[7:0];
		end else if (acc(rd_now, addr_r, IDX_ALT_LO)) begin
			alt_hold_r <= 1'b0;
		end
	end

	// Compare value: a high write holds off matching until the low byte lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_r <= CMP_RESET;
			cmp_hold_r <= 1'b0;
		end else if (acc(wr_now, addr_r, IDX_CMP_HI)) begin
			compare_r[15:8] <= wbyte;
			cmp_hold_r <= 1'b1;
		end else if (acc(wr_now, addr_r, IDX_CMP_LO)) begin
			compare_r[7:0] <= wbyte;
			cmp_hold_r <= 1'b0;
		end
	end

	assign cmp_match = cnt.tick && (cnt.count == compare_r) && !cmp_hold_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_r <= 1'b0;
		end else if (cmp_match) begin
			pin_r <= out_lvl_r;
		end
	end

	assign compare_output_pin = pin_r;

	// Clear arming: a flags read that sees a flag set arms its clear; the matching
	// low-byte read (for compare, a read or a write) then clears. Arming survives until that access.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_arm_r <= 1'b0;
			cmp_arm_r <= 1'b0;
			ovf_arm_r <= 1'b0;
		end else if (acc(rd_now, addr_r, IDX_FLAGS)) begin
			cap_arm_r <= cap_flag_r || cap_arm_r;
			cmp_arm_r <= cmp_flag_r || cmp_arm_r;
			ovf_arm_r <= ovf_flag_r || ovf_arm_r;
		end else begin
			if (cap_clr) begin
				cap_arm_r <= 1'b0;
			end
			if (cmp_clr) begin
				cmp_arm_r <= 1'b0;
			end
			if (ovf_clr) begin
				ovf_arm_r <= 1'b0;
			end
		end
	end

	assign cap_clr = cap_arm_r && acc(rd_now, addr_r, IDX_CAP_LO);
	assign cmp_clr = cmp_arm_r && (acc(rd_now, addr_r, IDX_CMP_LO) || acc(wr_now, addr_r, IDX_CMP_LO));
	assign ovf_clr = ovf_arm_r && acc(rd_now, addr_r, IDX_CNT_LO);

	// Flags ignore hresetn; a set in the clearing cycle wins
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			cap_flag_r <= 1'b0;
			cmp_flag_r <= 1'b0;
			ovf_flag_r <= 1'b0;
		end else begin
			cap_flag_r <= cap_set || (cap_flag_r && !cap_clr);
			cmp_flag_r <= cmp_match || (cmp_flag_r && !cmp_clr);
			ovf_flag_r <= cnt.wrap || (ovf_flag_r && !ovf_clr);
		end
	end

	// Also the wake-up request out of wait; no flag sets in stop, so a capture in stop raises it only after stop ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (cap_flag_r && cap_ie_r) || (cmp_flag_r && cmp_ie_r) || (ovf_flag_r && ovf_ie_r);
		end
	end

	assign timer_irq = irq_r;

	// hsize is accepted but only whole-word transfers are expected
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, hwdata[31:8]};
endmodule

// file: sim/cct_timer_chk.sv
module cct_timer_chk import cct_pkg::*; (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Wdata
	input wire logic hready, // Ready in
	input wire logic [31:0] hrdata, // Rdata
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic compare_output_pin, // Pin
	input wire logic stop_mode, // Stop
	input wire logic timer_irq // Irq
);
	timeunit 1ns;
	timeprecision 100ps;
	logic ctl_wr_r;
	logic [7:0] ctl_r;
	// Shadow of the control register, rebuilt from the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_wr_r <= 1'b0;
		end else if (hready) begin
			ctl_wr_r <= hsel && htrans == HTRANS_NONSEQ && hwrite && haddr == {22'h0, IDX_CONTROL, 2'h0};
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_r <= 8'h00;
		end else if (hready && ctl_wr_r) begin
			ctl_r <= hwdata[7:0];
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence rd_req;
		hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	endsequence
	sequence wr_req;
		hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
	endsequence
	sequence rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_resp_okay: assert property (hresp == HRESP_OKAY) else $error("response not OKAY");
	a_read_wait: assert property (rd_req |=> rd_wait) else $error("read wait state wrong");
	a_write_nowait: assert property (wr_req |=> hreadyout) else $error("write stalled");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
	a_unmapped_zero: assert property (rd_req ##0 haddr[9:2] < IDX_CONTROL |-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
	a_irq_masked: assert property (timer_irq |-> $past(ctl_r[7:5]) != 3'h0)
		else $error("interrupt while disabled");
	a_pin_level: assert property ($changed(compare_output_pin) |-> compare_output_pin == $past(ctl_r[0]))
		else $error("compare pin took wrong level");
	a_pin_spacing: assert property ($changed(compare_output_pin) |=> !$changed(compare_output_pin) [*3])
		else $error("compare faster than prescaler");
	a_stop_frozen: assert property (stop_mode [*4] |-> $stable(compare_output_pin))
		else $error("compare pin moved in stop");
endmodule
bind cct_timer cct_timer_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .compare_output_pin, .stop_mode, .timer_irq);

// file: sim/cct_cap_src.sv
module cct_cap_src (
	input wire logic hclk, // Clock
	input wire logic compare_output_pin, // Load, observed only
	output logic capture_input_pin // Event source
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		capture_input_pin = 1'b0;
	end
	// Edges land 3 ns after a sampling edge, after a random 0 to 3 cycles
	task automatic drive(input logic lvl, input logic [1:0] dly);
		repeat (dly) @(posedge hclk);
		#3 capture_input_pin = lvl;
	endtask
endmodule

// file: sim/cct_timer_tb.sv
module cct_timer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import cct_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_mode = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, cap_pin, cmp_pin, irq;
	logic [31:0] rng = 32'h00009DFC; // Seed 40444
	logic [15:0] a, v, t;
	int fails = 0, num_checks = 0, cyc = 0;
	cct_timer i_dut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .capture_input_pin(cap_pin),
		.compare_output_pin(cmp_pin), .stop_mode, .timer_irq(irq));
	cct_cap_src i_src (.hclk, .compare_output_pin(cmp_pin), .capture_input_pin(cap_pin));
	always #4 hclk = ~hclk;
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {rng[31:8], wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rd16(input logic [7:0] idx, output logic [15:0] val);
		xfer(1'b0, idx, 8'h00);
		val[15:8] = rd[7:0];
		xfer(1'b0, idx + 8'h01, 8'h00);
		val[7:0] = rd[7:0];
	endtask
	// Masked update sequence: high, flags, low
	task automatic wr16(input logic [15:0] val);
		xfer(1'b1, IDX_CMP_HI, val[15:8]);
		xfer(1'b0, IDX_FLAGS, 8'h00);
		xfer(1'b1, IDX_CMP_LO, val[7:0]);
	endtask
	task automatic fl(input logic [2:0] e);
		xfer(1'b0, IDX_FLAGS, 8'h00);
		chk({29'h0, rd[7:5]}, {29'h0, e});
	endtask
	task automatic pin(input logic lvl);
		logic [31:0] r;
		r = rnd();
		i_src.drive(lvl, r[1:0]);
		repeat (8) @(posedge hclk);
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		rd16(IDX_CNT_HI, v);
		chk({16'h0, v & 16'hFFFE}, 32'h0000FFFC);
		xfer(1'b0, IDX_CONTROL, 8'h00);
		chk(rd & 32'hE3, 32'h0);
		rd16(IDX_CMP_HI, v);
		chk({16'h0, v}, {16'h0, CMP_RESET});
		repeat (40) @(posedge hclk);
		fl(3'b011);
		rd16(IDX_ALT_HI, v);
		fl(3'b011);
		xfer(1'b0, IDX_CNT_LO, 8'h00);
		fl(3'b010);
		xfer(1'b0, IDX_CMP_LO, 8'h00);
		fl(3'b000);
		xfer(1'b1, 8'h05, rng[7:0]);
		xfer(1'b0, 8'h05, 8'h00);
		chk(rd, 32'h0);
		rd16(IDX_ALT_HI, a);
		repeat (400) @(posedge hclk);
		rd16(IDX_ALT_HI, v);
		t = v - a - 16'd100;
		chk({31'h0, t <= 16'd3}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, IDX_CONTROL, {6'h0, i[0], 1'b0});
			pin(~i[0]);
			fl(3'b000);
			rd16(IDX_ALT_HI, a);
			pin(i[0]);
			fl(3'b100);
			rd16(IDX_CAP_HI, v);
			t = v - a;
			chk({31'h0, t <= 16'd4}, 32'h1);
			fl(3'b000);
		end
		pin(1'b0);
		xfer(1'b0, IDX_CAP_HI, 8'h00);
		a[15:8] = rd[7:0];
		pin(1'b1);
		xfer(1'b0, IDX_CAP_LO, 8'h00);
		a[7:0] = rd[7:0];
		chk({16'h0, a}, {16'h0, v});
		xfer(1'b1, IDX_CAP_HI, rng[7:0]);
		xfer(1'b1, IDX_CAP_LO, rng[15:8]);
		fl(3'b100);
		rd16(IDX_CAP_HI, a);
		chk({16'h0, a}, {16'h0, v});
		fl(3'b000);
		xfer(1'b1, IDX_CONTROL, 8'h03);
		rd16(IDX_ALT_HI, a);
		t = a + 16'd16;
		wr16(t);
		repeat (100) @(posedge hclk);
		chk({31'h0, cmp_pin}, 32'h1);
		fl(3'b010);
		xfer(1'b0, IDX_CMP_LO, 8'h00);
		chk({24'h0, rd[7:0]}, {24'h0, t[7:0]});
		fl(3'b000);
		xfer(1'b1, IDX_CONTROL, 8'h02);
		rd16(IDX_ALT_HI, a);
		t = a + 16'd16;
		xfer(1'b1, IDX_CMP_LO, t[7:0]);
		xfer(1'b1, IDX_CMP_HI, t[15:8]);
		repeat (100) @(posedge hclk);
		chk({31'h0, cmp_pin}, 32'h1);
		fl(3'b000);
		t = t + 16'd40;
		wr16(t);
		repeat (160) @(posedge hclk);
		chk({31'h0, cmp_pin}, 32'h0);
		fl(3'b010);
		// Rewrite the value already passed, so no fresh match can set the flag again
		xfer(1'b1, IDX_CMP_LO, t[7:0]);
		fl(3'b000);
		xfer(1'b1, IDX_CONTROL, 8'h82);
		pin(1'b0);
		stop_mode <= 1'b1;
		repeat (2) @(posedge hclk);
		rd16(IDX_ALT_HI, a);
		pin(1'b1);
		repeat (40) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		rd16(IDX_ALT_HI, v);
		chk({16'h0, v}, {16'h0, a});
		stop_mode <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		rd16(IDX_CAP_HI, v);
		chk({16'h0, v}, {16'h0, a});
		fl(3'b100);
		xfer(1'b0, IDX_CAP_LO, 8'h00);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, IDX_CONTROL, 8'hE2);
		pin(1'b0);
		stop_mode <= 1'b1;
		pin(1'b1);
		hresetn <= 1'b0;
		stop_mode <= 1'b0;
		pin(1'b0);
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rd16(IDX_CNT_HI, v);
		chk({16'h0, v & 16'hFFFE}, 32'h0000FFFC);
		xfer(1'b0, IDX_CONTROL, 8'h00);
		chk(rd & 32'hE3, 32'h02);
		xfer(1'b0, IDX_FLAGS, 8'h00);
		chk({31'h0, rd[7]}, 32'h0);
		// Compare and overflow flags set once the count runs through FFFF
		xfer(1'b1, IDX_CONTROL, 8'h42);
		repeat (20) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, IDX_CONTROL, 8'h22);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, IDX_CONTROL, 8'h02);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		fl(3'b011);
		end_sim();
	end
endmodule
